// ==== hdl/eu_pkg.sv ====
// Shared constants, types and helper functions of the execution-unit slice.
// Assumes a single core clock domain and a synchronous active-low reset.
`default_nettype none
package eu_pkg;
    // ----------------------------------------------------------------
    // Sizes and register map
    // ----------------------------------------------------------------
    localparam int          ADDR_W     = 4;
    localparam int          DATA_W     = 32;
    localparam int          PC_W       = 24;
    localparam int          POS_W      = 3;
    localparam int          STK_DEPTH  = 8;
    localparam logic [3:0]  REG_FLAGS  = 4'h0;
    localparam logic [3:0]  REG_PC     = 4'h4;
    localparam logic [3:0]  REG_STAT   = 4'h8;
    localparam int          FLG_C      = 0;
    localparam int          FLG_V      = 1;
    localparam int          FLG_Z      = 2;
    localparam int          FLG_N      = 3;
    localparam int          STAT_TAKEN = 0;
    localparam int          STAT_OVF   = 1;
    localparam int          STAT_UNF   = 2;
    localparam int          STAT_FULL  = 3;
    localparam int          STAT_EMPTY = 4;
    localparam logic [3:0]  FLAGS_RST  = 4'h0;
    localparam logic [23:0] PC_RST     = 24'h000000;

    // ----------------------------------------------------------------
    // Operation, condition and state encodings
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE                = 4'h0,
        OP_BIT_OR_CARRY        = 4'h1,
        OP_BIT_INV_OR_CARRY    = 4'h2,
        OP_BIT_XOR_CARRY       = 4'h3,
        OP_BIT_INV_XOR_CARRY   = 4'h4,
        OP_BIT_LOAD_CARRY      = 4'h5,
        OP_BIT_INV_LOAD_CARRY  = 4'h6,
        OP_BIT_STORE_CARRY     = 4'h7,
        OP_BIT_INV_STORE_CARRY = 4'h8,
        OP_BRANCH_COND         = 4'h9,
        OP_JUMP_UNCOND         = 4'ha,
        OP_BRANCH_SUBROUTINE   = 4'hb,
        OP_JUMP_SUBROUTINE     = 4'hc,
        OP_RETURN              = 4'hd
    } eu_op_t;

    typedef enum logic [3:0] {
        CC_BRANCH_ALWAYS     = 4'h0,
        CC_BRANCH_NEVER      = 4'h1,
        CC_BRANCH_HIGHER     = 4'h2,
        CC_BRANCH_LOWER_SAME = 4'h3,
        CC_BRANCH_HIGHER_SAME = 4'h4,
        CC_BRANCH_LOWER      = 4'h5,
        CC_BRANCH_NOT_EQUAL  = 4'h6,
        CC_BRANCH_EQUAL      = 4'h7,
        CC_BRANCH_OVF_CLEAR  = 4'h8,
        CC_BRANCH_OVF_SET    = 4'h9,
        CC_BRANCH_PLUS       = 4'ha,
        CC_BRANCH_MINUS      = 4'hb,
        CC_BRANCH_SIGNED_GE  = 4'hc,
        CC_BRANCH_SIGNED_LT  = 4'hd,
        CC_BRANCH_SIGNED_GT  = 4'he,
        CC_BRANCH_SIGNED_LE  = 4'hf
    } eu_cond_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_RET = 2'b10
    } eu_state_t;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic eu_sel_bit(input logic [7:0] data, input logic [2:0] pos);
        eu_sel_bit = data[pos];
    endfunction : eu_sel_bit

    function automatic logic eu_cond_eval(input logic [3:0] cc, input logic [3:0] f);
        logic c;
        logic z;
        logic nv;
        logic r;
        c  = f[FLG_C];
        z  = f[FLG_Z];
        nv = f[FLG_N] ^ f[FLG_V];
        case (cc)
            CC_BRANCH_ALWAYS:      r = 1'b1;
            CC_BRANCH_NEVER:       r = 1'b0;
            CC_BRANCH_HIGHER:      r = ~(c | z);
            CC_BRANCH_LOWER_SAME:  r = c | z;
            CC_BRANCH_HIGHER_SAME: r = ~c;
            CC_BRANCH_LOWER:       r = c;
            CC_BRANCH_NOT_EQUAL:   r = ~z;
            CC_BRANCH_EQUAL:       r = z;
            CC_BRANCH_OVF_CLEAR:   r = ~f[FLG_V];
            CC_BRANCH_OVF_SET:     r = f[FLG_V];
            CC_BRANCH_PLUS:        r = ~f[FLG_N];
            CC_BRANCH_MINUS:       r = f[FLG_N];
            CC_BRANCH_SIGNED_GE:   r = ~nv;
            CC_BRANCH_SIGNED_LT:   r = nv;
            CC_BRANCH_SIGNED_GT:   r = ~(z | nv);
            default:               r = z | nv;
        endcase
        eu_cond_eval = r;
    endfunction : eu_cond_eval
endpackage : eu_pkg
`default_nettype wire

// ==== hdl/eu_ifs.sv ====
// Internal carriers between the execution-unit top and its two helpers.
// Assumes both ends run on the same core clock.
`default_nettype none
interface eu_bit_if;
    import eu_pkg::*;
    logic [3:0] kind;
    logic       use_reg;
    logic [2:0] imm_pos;
    logic [2:0] reg_pos;
    logic [7:0] data;
    logic       carry;
    logic       carry_nxt;
    logic [7:0] byte_nxt;
    logic       carry_we;
    logic       byte_we;
    modport core (output kind, use_reg, imm_pos, reg_pos, data, carry,
                  input  carry_nxt, byte_nxt, carry_we, byte_we);
    modport unit (input  kind, use_reg, imm_pos, reg_pos, data, carry,
                  output carry_nxt, byte_nxt, carry_we, byte_we);
endinterface : eu_bit_if

interface eu_stk_if #(parameter int PC_W = 24);
    logic            push;
    logic            pop;
    logic [PC_W-1:0] wdata;
    logic [PC_W-1:0] rdata;
    logic            full;
    logic            empty;
    modport core (output push, pop, wdata, input rdata, full, empty);
    modport mem  (input push, pop, wdata, output rdata, full, empty);
endinterface : eu_stk_if
`default_nettype wire

// ==== hdl/eu_bitunit.sv ====
// Single-bit carry operations: selects the operand bit and forms new carry or byte.
// Assumes the caller registers the results; this module is purely combinational.
`default_nettype none
module eu_bitunit
    import eu_pkg::*;
(
    eu_bit_if.unit bi
);
    // ----------------------------------------------------------------
    // Bit position and operand bit
    // ----------------------------------------------------------------
    wire       inv_op = (bi.kind == OP_BIT_INV_OR_CARRY) || (bi.kind == OP_BIT_INV_XOR_CARRY) ||
                        (bi.kind == OP_BIT_INV_LOAD_CARRY) || (bi.kind == OP_BIT_INV_STORE_CARRY);
    // Inverted forms have no register-sourced position, so use_reg is ignored.
    wire [2:0] pos    = (!inv_op && bi.use_reg) ? bi.reg_pos : bi.imm_pos;
    wire       obit   = eu_sel_bit(bi.data, pos);
    wire       sbit   = (bi.kind == OP_BIT_INV_STORE_CARRY) ? ~bi.carry : bi.carry;

    // ----------------------------------------------------------------
    // Results
    // ----------------------------------------------------------------
    always_comb begin
        bi.carry_nxt = bi.carry;
        bi.carry_we  = 1'b1;
        bi.byte_we   = 1'b0;
        bi.byte_nxt  = bi.data;
        bi.byte_nxt[pos] = sbit;
        case (bi.kind)
            OP_BIT_OR_CARRY:        bi.carry_nxt = bi.carry | obit;
            OP_BIT_INV_OR_CARRY:    bi.carry_nxt = bi.carry | ~obit;
            OP_BIT_XOR_CARRY:       bi.carry_nxt = bi.carry ^ obit;
            OP_BIT_INV_XOR_CARRY:   bi.carry_nxt = bi.carry ^ ~obit;
            OP_BIT_LOAD_CARRY:      bi.carry_nxt = obit;
            OP_BIT_INV_LOAD_CARRY:  bi.carry_nxt = ~obit;
            OP_BIT_STORE_CARRY,
            OP_BIT_INV_STORE_CARRY: begin
                bi.carry_we = 1'b0;
                bi.byte_we  = 1'b1;
            end
            default:                bi.carry_we = 1'b0;
        endcase
    end
endmodule : eu_bitunit
`default_nettype wire

// ==== hdl/eu_rstack.sv ====
// Return-address stack with registered read data holding the popped word.
// Assumes the caller never pushes and pops in the same cycle.
`default_nettype none
module eu_rstack
    import eu_pkg::*;
#(
    parameter int DEPTH = STK_DEPTH,
    parameter int PW    = PC_W
)(
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic ce,
    eu_stk_if.mem     sk
);
    localparam int SP_W = $clog2(DEPTH + 1);

    logic [PW-1:0]   mem_r [DEPTH];
    logic [SP_W-1:0] sp_r;
    logic [PW-1:0]   rdata_r;

    wire do_push = sk.push && (sp_r != SP_W'(DEPTH));
    wire do_pop  = sk.pop && (sp_r != '0);

    assign sk.rdata = rdata_r;
    assign sk.full  = (sp_r == SP_W'(DEPTH));
    assign sk.empty = (sp_r == '0);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (ce && do_push) begin
            mem_r[sp_r[$clog2(DEPTH)-1:0]] <= sk.wdata;
        end
        if (ce && do_pop) begin
            rdata_r <= mem_r[sp_r[$clog2(DEPTH)-1:0] - 1'b1];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sp_r <= '0;
        end else if (ce && do_push) begin
            sp_r <= sp_r + 1'b1;
        end else if (ce && do_pop) begin
            sp_r <= sp_r - 1'b1;
        end
    end
endmodule : eu_rstack
`default_nettype wire

// ==== hdl/eu_core.sv ====
// Execution-unit slice: bit-through-carry operations, branch predicates and flow control.
// Assumes decode presents one operation per accepted cycle and holds it while op_ready_r is low.
//
// Operation
// - Or-to-carry: carry becomes carry OR bit.
// - Inverted or: carry becomes carry OR NOT bit.
// - Xor-to-carry: carry becomes carry XOR bit.
// - Inverted xor: carry becomes carry XOR NOT bit.
// - Bit load copies operand bit into carry.
// - Inverted load writes complemented bit into carry.
// - Bit store writes carry, other bits kept.
// - Inverted store writes complemented carry into bit.
// - Inverted forms take position from immediate only.
// - Plain forms: immediate or register low bits.
// - Branch taken only when condition true.
// - Always, never, equal, overflow, sign conditions.
// - Unsigned conditions from carry and zero.
// - Signed conditions from zero, negative, overflow.
//
// Implementation choices: the placing of the registers and the strobed register port.
`default_nettype none
module eu_core
    import eu_pkg::*;
#(
    parameter int DEPTH = STK_DEPTH
)(
    input  wire logic              mclk,
    input  wire logic              rstn,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata_r,
    input  wire logic              op_valid,
    input  wire logic [3:0]        op_kind,
    input  wire logic              op_use_reg,
    input  wire logic [2:0]        op_imm_pos,
    input  wire logic [7:0]        op_reg_val,
    input  wire logic [7:0]        op_byte,
    input  wire logic [3:0]        op_cond,
    input  wire logic [PC_W-1:0]   op_target,
    input  wire logic [PC_W-1:0]   op_next_pc,
    output logic                   op_ready_r,
    output logic                   done_r,
    output logic      [7:0]        byte_out_r,
    output logic                   byte_we_r,
    output logic                   taken_r,
    output logic      [PC_W-1:0]   pc_r,
    output logic      [3:0]        flags_r
);
    // ----------------------------------------------------------------
    // Helpers and state
    // ----------------------------------------------------------------
    eu_bit_if            bi ();
    eu_stk_if #(.PC_W(PC_W)) sk ();

    eu_state_t  state_r;
    eu_state_t  state_nxt;
    logic       ovf_r;
    logic       unf_r;
    logic [3:0] flags_nxt;
    logic [PC_W-1:0] pc_nxt;

    eu_bitunit u_bit (
        .bi (bi)
    );

    eu_rstack #(.DEPTH(DEPTH), .PW(PC_W)) u_stk (
        .mclk (mclk),
        .rstn (rstn),
        .ce   (ce),
        .sk   (sk)
    );

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire accept     = ce && op_valid && op_ready_r;
    wire is_branch  = (op_kind == OP_BRANCH_COND);
    wire is_jump    = (op_kind == OP_JUMP_UNCOND);
    wire is_call    = (op_kind == OP_BRANCH_SUBROUTINE) || (op_kind == OP_JUMP_SUBROUTINE);
    wire is_ret     = (op_kind == OP_RETURN);
    wire is_flow    = is_branch || is_jump || is_call || is_ret;
    wire cond_true  = eu_cond_eval(op_cond, flags_r);
    wire take       = (is_branch && cond_true) || is_jump || is_call;
    wire wr_flags   = reg_wr && (reg_addr == REG_FLAGS);
    wire call_drop  = accept && is_call && sk.full;
    wire ret_drop   = accept && is_ret && sk.empty;

    assign bi.kind    = accept ? op_kind : OP_NONE;
    assign bi.use_reg = op_use_reg;
    assign bi.imm_pos = op_imm_pos;
    assign bi.reg_pos = op_reg_val[2:0];
    assign bi.data    = op_byte;
    assign bi.carry   = flags_r[FLG_C];

    // Unless the stack is full, the return address is saved on the same clock edge that control moves to the target.
    assign sk.push  = accept && is_call;
    assign sk.pop   = accept && is_ret;
    assign sk.wdata = op_next_pc;

    // ----------------------------------------------------------------
    // Next-state selection
    // ----------------------------------------------------------------
    // An executing operation's carry update wins over a software flag write in the same cycle.
    always_comb begin
        flags_nxt = wr_flags ? reg_wdata[3:0] : flags_r;
        if (bi.carry_we) begin
            flags_nxt[FLG_C] = bi.carry_nxt;
        end
    end

    always_comb begin
        pc_nxt    = pc_r;
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (accept && is_ret && !sk.empty) begin
                    state_nxt = ST_RET;
                end else if (accept && take) begin
                    pc_nxt = op_target;
                end else if (accept) begin
                    pc_nxt = op_next_pc;
                end
            end
            ST_RET: begin
                pc_nxt    = sk.rdata;
                state_nxt = ST_RUN;
            end
            default: state_nxt = ST_RUN;
        endcase
    end

    wire [DATA_W-1:0] stat_word = {{(DATA_W-5){1'b0}}, sk.empty, sk.full, unf_r, ovf_r, taken_r};
    wire [DATA_W-1:0] rd_word   = (reg_addr == REG_FLAGS) ? {{(DATA_W-4){1'b0}}, flags_r} :
                                  (reg_addr == REG_PC)    ? {{(DATA_W-PC_W){1'b0}}, pc_r} :
                                  (reg_addr == REG_STAT)  ? stat_word : '0;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_r <= ST_RUN;
            pc_r    <= PC_RST;
            flags_r <= FLAGS_RST;
        end else if (ce) begin
            state_r <= state_nxt;
            pc_r    <= pc_nxt;
            flags_r <= flags_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            op_ready_r <= 1'b1;
            done_r     <= 1'b0;
            taken_r    <= 1'b0;
        end else if (ce) begin
            op_ready_r <= (state_nxt == ST_RUN);
            done_r     <= (accept && !(is_ret && !sk.empty)) || (state_r == ST_RET);
            if (accept && is_flow) begin
                taken_r <= take || (is_ret && !sk.empty);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            byte_out_r <= 8'h00;
            byte_we_r  <= 1'b0;
        end else if (ce) begin
            byte_we_r <= bi.byte_we;
            if (bi.byte_we) begin
                byte_out_r <= bi.byte_nxt;
            end
        end
    end

    // Sticky stack errors; a new error in the clearing cycle is kept.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ovf_r <= 1'b0;
            unf_r <= 1'b0;
        end else if (ce) begin
            ovf_r <= call_drop || (ovf_r && !(reg_wr && reg_addr == REG_STAT && reg_wdata[STAT_OVF]));
            unf_r <= ret_drop || (unf_r && !(reg_wr && reg_addr == REG_STAT && reg_wdata[STAT_UNF]));
        end
    end

    // Read data stand in the cycle after the strobe only; the bus never waits.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            reg_rdata_r <= '0;
        end else if (ce) begin
            reg_rdata_r <= reg_rd ? rd_word : '0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    wire        chk_obit   = eu_sel_bit(op_byte, op_use_reg ? op_reg_val[2:0] : op_imm_pos);
    wire        chk_imbit  = eu_sel_bit(op_byte, op_imm_pos);
    wire        chk_go     = accept && state_r == ST_RUN;

    AST_OR_CARRY: assert property (
        @(posedge mclk) disable iff (!rstn)
        (chk_go && op_kind == OP_BIT_OR_CARRY) |=>
            flags_r[FLG_C] == ($past(flags_r[FLG_C]) | $past(chk_obit)))
        else $error("Or-to-carry result wrong.");

    AST_INV_OR_CARRY: assert property (
        @(posedge mclk) disable iff (!rstn)
        (chk_go && op_kind == OP_BIT_INV_OR_CARRY) |=>
            flags_r[FLG_C] == ($past(flags_r[FLG_C]) | ~$past(chk_imbit)))
        else $error("Inverted or-to-carry result wrong.");

    AST_XOR_CARRY: assert property (
        @(posedge mclk) disable iff (!rstn)
        (chk_go && op_kind == OP_BIT_XOR_CARRY) |=>
            flags_r[FLG_C] == ($past(flags_r[FLG_C]) ^ $past(chk_obit)))
        else $error("Xor-to-carry result wrong.");

    AST_INV_XOR_CARRY: assert property (
        @(posedge mclk) disable iff (!rstn)
        (chk_go && op_kind == OP_BIT_INV_XOR_CARRY) |=>
            flags_r[FLG_C] != ($past(flags_r[FLG_C]) ^ $past(chk_imbit)))
        else $error("Inverted xor-to-carry result wrong.");

    AST_LOAD_CARRY: assert property (
        @(posedge mclk) disable iff (!rstn)
        (chk_go && op_kind == OP_BIT_LOAD_CARRY) |=> flags_r[FLG_C] == $past(chk_obit))
        else $error("Bit load did not copy the bit.");

    AST_INV_LOAD_CARRY: assert property (
        @(posedge mclk) disable iff (!rstn)
        (chk_go && op_kind == OP_BIT_INV_LOAD_CARRY) |=> flags_r[FLG_C] == !$past(chk_imbit))
        else $error("Inverted bit load wrong.");

    AST_STORE_CARRY: assert property (
        @(posedge mclk) disable iff (!rstn)
        (chk_go && op_kind == OP_BIT_STORE_CARRY && !op_use_reg) |=>
            byte_we_r && byte_out_r[$past(op_imm_pos)] == $past(flags_r[FLG_C]) &&
            ((byte_out_r ^ $past(op_byte)) & ~(8'h01 << $past(op_imm_pos))) == 8'h00)
        else $error("Bit store corrupted the byte.");

    AST_INV_STORE_CARRY: assert property (
        @(posedge mclk) disable iff (!rstn)
        (chk_go && op_kind == OP_BIT_INV_STORE_CARRY) |=>
            byte_we_r && byte_out_r[$past(op_imm_pos)] == !$past(flags_r[FLG_C]))
        else $error("Inverted bit store wrong.");

    AST_BRANCH_PC: assert property (
        @(posedge mclk) disable iff (!rstn)
        (chk_go && is_branch) |=>
            pc_r == ($past(cond_true) ? $past(op_target) : $past(op_next_pc)))
        else $error("Branch went to the wrong address.");

    AST_RETURN: assert property (
        @(posedge mclk) disable iff (!rstn)
        (chk_go && is_call && !sk.full && ce) ##1 (ce && op_valid && op_ready_r && is_ret)
            |=> !op_ready_r ##1 ($past(ce) ? pc_r == $past(op_next_pc, 3) : 1'b1))
        else $error("Return did not restore the saved address.");
endmodule : eu_core
`default_nettype wire

// ==== verif/eu_core_test.sv ====
// Self-checking bench of the execution-unit slice: bit-through-carry ops, branch predicates, calls.
// Assumes one core clock and that the design keeps ce low only when told; ce is held high except in the clock-enable scenario.
`default_nettype none
module eu_core_test
    import eu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------------------------------------
    // Signals and instance
    // --------------------------------------------------------------
    logic mclk = 1'b0, rstn = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, op_valid = 1'b0, op_use_reg = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata_r;
    logic [3:0] op_kind = '0, op_cond = '0, flags_r;
    logic [2:0] op_imm_pos = '0;
    logic [7:0] op_reg_val = '0, op_byte = '0, byte_out_r;
    logic [PC_W-1:0] op_target = '0, op_next_pc = '0, pc_r;
    logic op_ready_r, done_r, byte_we_r, taken_r;
    int error_cnt = 0, total_checks = 0;
    logic [31:0] seed = 32'd91;
    always #4 mclk = ~mclk;
    eu_core #(.DEPTH(2)) eu_core_inst (.mclk(mclk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
        .op_valid(op_valid), .op_kind(op_kind), .op_use_reg(op_use_reg), .op_imm_pos(op_imm_pos),
        .op_reg_val(op_reg_val), .op_byte(op_byte), .op_cond(op_cond), .op_target(op_target),
        .op_next_pc(op_next_pc), .op_ready_r(op_ready_r), .done_r(done_r), .byte_out_r(byte_out_r),
        .byte_we_r(byte_we_r), .taken_r(taken_r), .pc_r(pc_r), .flags_r(flags_r));
    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic cond_ok(input logic [3:0] cc, input logic [3:0] f);
        logic c, v, z, n;
        {n, z, v, c} = f;
        case (cc)
            4'h0: return 1'b1;
            4'h1: return 1'b0;
            4'h2: return (c | z) == 1'b0;
            4'h3: return (c | z) == 1'b1;
            4'h4: return c == 1'b0;
            4'h5: return c == 1'b1;
            4'h6: return z == 1'b0;
            4'h7: return z == 1'b1;
            4'h8: return v == 1'b0;
            4'h9: return v == 1'b1;
            4'ha: return n == 1'b0;
            4'hb: return n == 1'b1;
            4'hc: return (n ^ v) == 1'b0;
            4'hd: return (n ^ v) == 1'b1;
            4'he: return (z | (n ^ v)) == 1'b0;
            default: return (z | (n ^ v)) == 1'b1;
        endcase
    endfunction : cond_ok
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata_r, exp, "register read");
    endtask : bus_rd
    task automatic do_op(input logic [3:0] k, input logic ur, input logic [2:0] ip, input logic [7:0] rv,
                         input logic [7:0] by, input logic [3:0] cc, input logic [23:0] tg, input logic [23:0] np);
        int n;
        @(posedge mclk);
        op_valid   <= 1'b1;
        op_kind    <= k;
        op_use_reg <= ur;
        op_imm_pos <= ip;
        op_reg_val <= rv;
        op_byte    <= by;
        op_cond    <= cc;
        op_target  <= tg;
        op_next_pc <= np;
        @(posedge mclk);
        op_valid <= 1'b0;
        #1 n = 0;
        while (done_r !== 1'b1 && n < 4) begin
            @(posedge mclk);
            #1 n++;
        end
        chk(n < 4, 1'b1, "operation completion");
    endtask : do_op
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report
    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    initial begin
        #200000 error_cnt++;
        final_report();
    end
    initial begin
        logic [31:0] r;
        logic [3:0] f, k;
        logic [2:0] p;
        logic c, b, plain;
        logic [7:0] eb;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        #1 chk({op_ready_r, flags_r, pc_r}, {1'b1, FLAGS_RST, PC_RST}, "reset state");
        bus_rd(4'hc, 32'h0);
        // Random bit ops; inverted forms must ignore the register position.
        for (int i = 0; i < 300; i++) begin
            r = rnd();
            f = r[3:0];
            k = 4'h1 + {1'b0, r[6:4]};
            c = f[0];
            bus_wr(REG_FLAGS, {28'h0, f});
            plain = (k == 4'h1 || k == 4'h3 || k == 4'h5 || k == 4'h7);
            p = (plain && r[8]) ? r[18:16] : r[11:9];
            eb = r[31:24];
            b = eb[p];
            do_op(k, r[8], r[11:9], r[23:16], r[31:24], 4'h0, 24'h0, r[23:0]);
            case (k)
                4'h1: c = c | b;
                4'h2: c = c | ~b;
                4'h3: c = c ^ b;
                4'h4: c = c ^ ~b;
                4'h5: c = b;
                4'h6: c = ~b;
                4'h7: eb[p] = c;
                default: eb[p] = ~c;
            endcase
            chk(flags_r, {f[3:1], c}, "carry after bit op");
            chk(pc_r, r[23:0], "next pc after bit op");
            chk(byte_we_r, k >= 4'h7, "store strobe");
            if (k >= 4'h7) chk(byte_out_r, eb, "stored byte");
        end
        // Every condition code under several random flag settings.
        for (int cc = 0; cc < 16; cc++) begin
            for (int j = 0; j < 6; j++) begin
                r = rnd();
                bus_wr(REG_FLAGS, {28'h0, r[3:0]});
                do_op(OP_BRANCH_COND, 1'b0, 3'h0, 8'h0, 8'h0, cc[3:0], r[31:8], ~r[31:8]);
                b = cond_ok(cc[3:0], r[3:0]);
                chk({taken_r, pc_r}, {b, b ? r[31:8] : ~r[31:8]}, "branch result");
            end
        end
        // Jump, both call forms, returns in order, then a return on an empty stack.
        do_op(OP_JUMP_UNCOND, 1'b0, 3'h0, 8'h0, 8'h0, 4'h0, 24'h000100, 24'h000002);
        chk({taken_r, pc_r}, {1'b1, 24'h000100}, "jump");
        do_op(OP_BRANCH_SUBROUTINE, 1'b0, 3'h0, 8'h0, 8'h0, 4'h0, 24'h000200, 24'h000102);
        chk(pc_r, 24'h000200, "branch call");
        do_op(OP_JUMP_SUBROUTINE, 1'b0, 3'h0, 8'h0, 8'h0, 4'h0, 24'h000300, 24'h000202);
        chk(pc_r, 24'h000300, "jump call");
        do_op(OP_RETURN, 1'b0, 3'h0, 8'h0, 8'h0, 4'h0, 24'h0, 24'h000302);
        chk({taken_r, pc_r}, {1'b1, 24'h000202}, "first return");
        do_op(OP_RETURN, 1'b0, 3'h0, 8'h0, 8'h0, 4'h0, 24'h0, 24'h000204);
        chk({taken_r, pc_r}, {1'b1, 24'h000102}, "second return");
        do_op(OP_RETURN, 1'b0, 3'h0, 8'h0, 8'h0, 4'h0, 24'h0, 24'h000104);
        chk({taken_r, pc_r}, {1'b0, 24'h000104}, "empty return");
        bus_rd(REG_STAT, 32'h00000014);
        bus_wr(REG_STAT, 32'h00000004);
        // A return right behind its call, so the pop meets a freshly pushed word.
        @(posedge mclk);
        op_valid   <= 1'b1;
        op_kind    <= OP_JUMP_SUBROUTINE;
        op_target  <= 24'h000600;
        op_next_pc <= 24'h000106;
        @(posedge mclk);
        op_kind <= OP_RETURN;
        @(posedge mclk);
        op_valid <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk({taken_r, pc_r}, {1'b1, 24'h000106}, "return behind call");
        // The third call finds the stack full: it still jumps, but the address is lost.
        for (int i = 0; i < 3; i++) begin
            do_op(OP_JUMP_SUBROUTINE, 1'b0, 3'h0, 8'h0, 8'h0, 4'h0, 24'h000400, 24'h000402);
        end
        bus_rd(REG_STAT, 32'h0000000b);
        // A request held while the clock enable is low must wait.
        @(posedge mclk);
        ce        <= 1'b0;
        op_valid  <= 1'b1;
        op_kind   <= OP_JUMP_UNCOND;
        op_target <= 24'h000500;
        repeat (3) @(posedge mclk);
        #1 chk({done_r, pc_r}, {1'b0, 24'h000400}, "frozen by clock enable");
        @(posedge mclk);
        ce <= 1'b1;
        @(posedge mclk);
        op_valid <= 1'b0;
        bus_rd(REG_PC, 32'h00000500);
        bus_wr(REG_FLAGS, 32'h0000000a);
        bus_rd(REG_FLAGS, 32'h0000000a);
        final_report();
    end
endmodule : eu_core_test
`default_nettype wire
